//--- core/asram_host.sv
// host controller driving a clockless static memory, one bit wide
// assumes memory pins are timed only by this block; inputs synchronous
`timescale 1ns/1ps
`default_nettype none
module asram_host (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [asram_pkg::ADDR_W-1:0] reqAddr,
   input wire logic reqData,
   output logic reqReady,
   output logic rspValid,
   output logic rspData,
   output logic [asram_pkg::ADDR_W-1:0] memAddr,
   output logic selectN,
   output logic writeStrobeN,
   output logic dataIn,
   input wire logic dataOut
);
   import asram_pkg::*;
   asram_tmr_if tmrBus ();
   asram_timer timerUnit (
      .ref_clk(ref_clk),
      .reset(reset),
      .tmr(tmrBus)
   );
   asram_state_t state, next_state;
   logic next_reqReady, next_rspValid, next_rspData;
   logic [ADDR_W-1:0] next_memAddr;
   logic next_selectN, next_writeStrobeN, next_dataIn;
   logic gapDone, next_gapDone;
   always_comb begin
      next_state = state;
      next_reqReady = reqReady;
      next_rspValid = 1'b0;
      next_rspData = rspData;
      next_memAddr = memAddr;
      next_selectN = selectN;
      next_writeStrobeN = writeStrobeN;
      next_dataIn = dataIn;
      next_gapDone = gapDone;
      tmrBus.load = 1'b0;
      tmrBus.count = 8'h00;
      unique case (state)
         ASRAM_IDLE: begin
            if (!gapDone && tmrBus.done) begin
               next_gapDone = 1'b1;
               next_reqReady = 1'b1;
            end
            if (reqReady && reqValid) begin
               next_reqReady = 1'b0;
               next_gapDone = 1'b0;
               next_memAddr = reqAddr;
               next_selectN = 1'b0;
               tmrBus.load = 1'b1;
               if (reqWrite) begin
                  // strobe falls with select; both low starts the write, see R2 R16
                  next_writeStrobeN = 1'b0;
                  next_dataIn = reqData;
                  next_state = ASRAM_WPULSE;
                  tmrBus.count = CNT_W'(WR_PULSE_CYC); // see R11 R12 R16
               end else begin
                  next_writeStrobeN = 1'b1; // see R1
                  next_state = ASRAM_READ;
                  tmrBus.count = CNT_W'(RD_CYC); // see R3 R9
               end
            end
         end
         ASRAM_READ: begin
            if (tmrBus.done) begin
               // sampled after access time; address held whole cycle, see R8 R4
               next_rspData = dataOut;
               next_rspValid = 1'b1;
               next_selectN = 1'b1;
               next_state = ASRAM_IDLE;
               // let output release before anyone drives again, see R6 R7
               tmrBus.load = 1'b1;
               tmrBus.count = CNT_W'(GAP_CYC);
            end
         end
         ASRAM_WPULSE: begin
            if (tmrBus.done) begin
               // data and address stay put past the rise, see R12 R14
               next_writeStrobeN = 1'b1;
               next_state = ASRAM_WHOLD;
               tmrBus.load = 1'b1;
               tmrBus.count = CNT_W'(WR_HOLD_CYC); // see R10 R15
            end
         end
         ASRAM_WHOLD: begin
            if (tmrBus.done) begin
               next_selectN = 1'b1;
               next_rspValid = 1'b1;
               next_state = ASRAM_IDLE;
               tmrBus.load = 1'b1;
               tmrBus.count = CNT_W'(GAP_CYC); // see R6 R13
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= ASRAM_IDLE;
         reqReady <= 1'b1;
         rspValid <= 1'b0;
         rspData <= 1'b0;
         memAddr <= 16'h0000;
         selectN <= 1'b1;
         writeStrobeN <= 1'b1;
         dataIn <= 1'b0;
         gapDone <= 1'b1;
      end else begin
         state <= next_state;
         reqReady <= next_reqReady;
         rspValid <= next_rspValid;
         rspData <= next_rspData;
         memAddr <= next_memAddr;
         selectN <= next_selectN;
         writeStrobeN <= next_writeStrobeN;
         dataIn <= next_dataIn;
         gapDone <= next_gapDone;
      end
   end
endmodule
`default_nettype wire

//--- core/asram_pkg.sv
// constants for the asynchronous static memory host controller
// assumes a 125 MHz ref_clk; the memory has no clock of its own
//
// Contract
// R1: read cycles keep write strobe high
// R2: memory writes only while select and strobe low
// R3: read cycle at least 35/45 ns
// R4: old read data held 3 ns after address
// R5: output off until 5 ns after select
// R6: output released 15/20 ns after deselect
// R7: release always faster than turn-on
// R8: selected reads follow address changes
// R9: read data valid within 35/45 ns
// R10: write cycle at least 30/40 ns
// R11: address valid 30/35 ns before strobe rise
// R12: data setup 15 ns, hold 3 ns
// R13: output off 15/20 ns after strobe fall
// R14: output may resume at strobe rise
// R15: host meets every minimum interval
// R16: deselect, read and write modes; pulse 30 ns
package asram_pkg;
   localparam int ADDR_W = 16;
   localparam int CLK_PERIOD_PS = 8000;
   // times in ns, slow grade figures so either grade is met
   localparam int T_READ_CYCLE_NS = 45;
   localparam int T_READ_ACCESS_NS = 45;
   localparam int T_WRITE_CYCLE_NS = 40;
   localparam int T_ADDR_TO_WEND_NS = 35;
   localparam int T_WRITE_PULSE_NS = 30;
   localparam int T_DATA_SETUP_NS = 15;
   localparam int T_DATA_HOLD_NS = 3;
   localparam int T_OFF_AFTER_DESEL_NS = 20;
   function automatic int cyclesUp(input int ns);
      return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   endfunction
   function automatic int maxOf(input int a, input int b);
      return (a > b) ? a : b;
   endfunction
   // access plus one cycle to sample safely
   localparam int RD_CYC = maxOf(cyclesUp(T_READ_CYCLE_NS), cyclesUp(T_READ_ACCESS_NS)) + 1;
   localparam int WR_PULSE_CYC = maxOf(maxOf(cyclesUp(T_WRITE_PULSE_NS),
      cyclesUp(T_ADDR_TO_WEND_NS)), cyclesUp(T_DATA_SETUP_NS));
   localparam int WR_HOLD_CYC = maxOf(cyclesUp(T_DATA_HOLD_NS),
      cyclesUp(T_WRITE_CYCLE_NS) - WR_PULSE_CYC);
   localparam int GAP_CYC = cyclesUp(T_OFF_AFTER_DESEL_NS);
   localparam int CNT_W = 8;
   typedef enum logic [1:0] {
      ASRAM_IDLE = 2'b00,
      ASRAM_READ = 2'b01,
      ASRAM_WPULSE = 2'b10,
      ASRAM_WHOLD = 2'b11
   } asram_state_t;
endpackage

//--- core/asram_tmr_if.sv
// timer handshake between sequencer and its cycle counter
// assumes both ends share ref_clk
`timescale 1ns/1ps
`default_nettype none
interface asram_tmr_if;
   logic load;
   logic [asram_pkg::CNT_W-1:0] count;
   logic done;
   modport ctrl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

//--- core/asram_timer.sv
// down counter that times each memory cycle phase
// assumes load is a one-cycle pulse with count at least 1
`timescale 1ns/1ps
`default_nettype none
module asram_timer (
   input wire logic ref_clk,
   input wire logic reset,
   asram_tmr_if.tmr tmr
);
   import asram_pkg::*;
   logic [CNT_W-1:0] remain;
   logic [CNT_W-1:0] next_remain;
   always_comb begin
      next_remain = remain;
      if (tmr.load) begin
         next_remain = tmr.count;
      end else if (remain != 8'h00) begin
         next_remain = remain - 8'h01;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         remain <= 8'h00;
      end else begin
         remain <= next_remain;
      end
   end
   // done in the cycle the last count runs out
   // load is computed from done, so done must not look back at load
   assign tmr.done = (remain == 8'h01);
endmodule
`default_nettype wire

//--- tb/asram_mem_model.sv
// one-bit clockless memory seen at clock resolution
// assumes host pins change only at ref_clk edges
`timescale 1ns/1ps
`default_nettype none
module asram_mem_model (
   input wire logic ref_clk,
   input wire logic [15:0] memAddr,
   input wire logic selectN,
   input wire logic writeStrobeN,
   input wire logic dataIn,
   output logic dataOut
);
   logic mem [0:65535];
   int age = 0;
   initial dataOut = 1'b0;
   always @(posedge ref_clk) begin
      if (!selectN && !writeStrobeN) mem[memAddr] <= dataIn;
      age <= (!selectN && writeStrobeN && $stable(memAddr)) ? age + 1 : 0;
      // garbage until access time, toggles when released
      dataOut <= (age >= 4) ? mem[memAddr] : ~dataOut;
   end
endmodule
`default_nettype wire

//--- tb/asram_host_sva.sv
// pin timing checks on the memory side of the host
// assumes ref_clk at 8 ns
`timescale 1ns/1ps
`default_nettype none
module asram_host_sva (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire logic [15:0] memAddr,
   input wire logic selectN,
   input wire logic writeStrobeN,
   input wire logic dataIn
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_read_no_write: assert property (reqValid && reqReady && !reqWrite |=> writeStrobeN [*7])
      else $error("strobe low in read");
   chk_read_len: assert property ($fell(selectN) && writeStrobeN |=> (!selectN && $stable(memAddr)) [*5])
      else $error("read too short");
   chk_write_len: assert property ($fell(writeStrobeN) |=> $stable(memAddr) [*5])
      else $error("write cycle short");
   chk_addr_to_end: assert property ($rose(writeStrobeN) |-> !$past(writeStrobeN, 5) && $past(memAddr, 5) == memAddr)
      else $error("address setup short");
   chk_data_window: assert property ($rose(writeStrobeN) |-> $past(dataIn, 2) == dataIn ##1 $stable(dataIn))
      else $error("data setup or hold");
   chk_strobe_sel: assert property (!writeStrobeN |-> !selectN)
      else $error("strobe without select");
   chk_desel_gap: assert property ($rose(selectN) |-> selectN [*3])
      else $error("deselect gap short");
   chk_rsp_pulse: assert property (rspValid |=> !rspValid)
      else $error("response longer than one cycle");
   chk_ready_gap: assert property ($rose(selectN) |-> !reqReady [*3])
      else $error("request taken inside release gap");
endmodule
`default_nettype wire
bind asram_host asram_host_sva i_sva (.ref_clk(ref_clk), .reset(reset), .reqValid(reqValid),
   .reqWrite(reqWrite), .reqReady(reqReady), .rspValid(rspValid), .memAddr(memAddr),
   .selectN(selectN),
   .writeStrobeN(writeStrobeN), .dataIn(dataIn));

//--- tb/tb.sv
// random write and read-back through host into memory model
// assumes one design clock at 125 MHz
`timescale 1ns/1ps
`default_nettype none
module tb;
   import asram_pkg::*;
   logic ref_clk = 0, reset = 1, reqValid = 0, reqWrite = 0, reqData = 0;
   logic [ADDR_W-1:0] reqAddr = '0, memAddr, a;
   logic reqReady, rspValid, rspData, selectN, writeStrobeN, dataIn, dataOut, d;
   logic shadow [logic [15:0]];
   int n_mismatch = 0, tests_run = 0;
   always #4 ref_clk = ~ref_clk;
   asram_host i_asram_host (.ref_clk(ref_clk), .reset(reset), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
      .rspValid(rspValid), .rspData(rspData), .memAddr(memAddr), .selectN(selectN),
      .writeStrobeN(writeStrobeN), .dataIn(dataIn), .dataOut(dataOut));
   asram_mem_model i_asram_mem_model (.ref_clk(ref_clk), .memAddr(memAddr), .selectN(selectN),
      .writeStrobeN(writeStrobeN), .dataIn(dataIn), .dataOut(dataOut));
   task automatic cmp_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [15:0] ad, input logic dv);
      int k;
      while (reqReady !== 1'b1) @(negedge ref_clk);
      reqValid = 1;
      reqWrite = w;
      reqAddr = ad;
      reqData = dv;
      @(negedge ref_clk);
      reqValid = 0;
      k = 0;
      while (rspValid !== 1'b1 && k < 20) begin
         @(negedge ref_clk);
         k++;
      end
      // a missing answer ends the wait at 20 and fails here
      cmp_val(k, w ? WR_PULSE_CYC + WR_HOLD_CYC : RD_CYC);
      if (w) shadow[ad] = dv;
      else cmp_bit(rspData, shadow[ad]);
   endtask
   initial begin
      // long-lived watchdog, well beyond the expected run
      #200000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(5585));
      repeat (16) @(negedge ref_clk);
      reset = 0;
      cmp_bit(selectN, 1'b1);
      cmp_bit(writeStrobeN, 1'b1);
      shadow.delete();
      xfer(1, 16'h0000, 1);
      xfer(1, 16'hffff, 0);
      xfer(1, 16'h0000, 0);
      xfer(0, 16'h0000, 0);
      xfer(0, 16'hffff, 0);
      repeat (30) begin
         a = 16'($urandom);
         d = 1'($urandom);
         xfer(1, a, d);
         xfer(1, a ^ 16'h0001, ~d);
         xfer(0, a, 0);
         xfer(0, a ^ 16'h0001, 0);
      end
      // reset in the middle of a release gap; memory contents survive it
      @(negedge ref_clk);
      reset = 1;
      repeat (2) @(negedge ref_clk);
      reset = 0;
      cmp_bit(selectN, 1'b1);
      cmp_bit(reqReady, 1'b1);
      cmp_bit(rspValid, 1'b0);
      cmp_val(memAddr, 32'h00000000);
      xfer(0, a, 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
